// ### verilog/reset_cause_unit.sv
// Purpose: reset cause tracking, time-outs and reset values of a small controller
// Assumes: presetn is the power-on reset; APB slave always ready, no wait states
// Notes: the registers below stand in for the core's own reset-sensitive registers
// Behaviour
// - config word sits at location 2007h
// - config space only in programming mode
// - seven reset and wake events told apart
// - some registers untouched by any reset
// - resets load defaults, watchdog wake does not
// - reset pin filter rejects short pulses
// - watchdog reset never drives the pin
// - brown-out flag one at power-on if enabled
// - hardware only clears brown-out flag
// - power-on flag cleared only at power-on
// - time-out length per oscillator mode
// - power-on and brown-out flag settings
// - time-out/power-down flags per wake or reset
// - power-on always sets both status flags
// - resets load 000h, wakes continue next
// - interrupt wake with enable takes vector
// - resets set all direction bits to inputs
// - wakes keep irq registers except waking flag
// - option, period, timer2, converter reset values
// - start-up timer waits oscillator, power-up timer
// - sleep clears power-down, watchdog clears time-out
`timescale 1ns/1ns
`default_nettype none
module reset_cause_unit
   import reset_cause_pkg::*;
#(
   parameter int POWERUP_COUNT = POWERUP_CYCLES,
   parameter int OSC_COUNT = OSC_STARTUP_PERIODS,
   parameter logic [13:0] CONFIG_DEFAULT = 14'h3FFF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_reset_pin_n,
   input wire logic brownout_detect,
   input wire logic watchdog_timeout,
   input wire logic irq_wake,
   input wire logic sleep_exec,
   input wire logic [12:0] sleep_pc,
   input wire logic global_irq_enable,
   input wire logic [7:0] wake_flags,
   input wire logic osc_tick,
   input wire logic programming_mode,
   output logic external_reset_pin_out,
   output logic external_reset_pin_oe,
   output logic core_reset_n,
   output logic fetch_enable,
   output logic [12:0] program_counter,
   output logic [5:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] option_register,
   output logic [7:0] timer_period_register,
   output logic [7:0] timer2_count,
   output logic [7:0] timer2_control_register,
   output logic [7:0] converter_control_register,
   output logic [7:0] interrupt_control_register,
   output logic [7:0] peripheral_irq_flags,
   output logic [7:0] scratch
);
   localparam int CW = 25;
   logic pin_n;
   logic [1:0] power_status;
   logic timeout_flag;
   logic powerdown_flag;
   logic sleeping;
   cause_t last_cause;
   seq_state_t state;
   logic [13:0] config_word;
   logic pup_done;
   logic osc_done;
   logic load_pup;
   logic load_osc;
   logic first_load;

   pin_glitch_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pin_n(external_reset_pin_n),
      .filtered_n(pin_n)
   );
   timeout_counter #(.WIDTH(CW)) u_pup (
      .pclk(pclk),
      .presetn(presetn),
      .load(load_pup),
      .count(CW'(POWERUP_COUNT)),
      .tick(1'b1),
      .done(pup_done)
   );
   timeout_counter #(.WIDTH(CW)) u_osc (
      .pclk(pclk),
      .presetn(presetn),
      .load(load_osc),
      .count(CW'(OSC_COUNT)),
      .tick(osc_tick),
      .done(osc_done)
   );

   // configuration fields: bits read zero when programmed
   wire rc_mode = (config_word[1:0] == 2'b11);
   wire powerup_timer_enable_n = config_word[3];
   wire brownout_enable_fuse = config_word[6];

   // event detection
   wire pin_event = !pin_n && state == ST_RUN;
   wire bo_event = brownout_detect && brownout_enable_fuse && state == ST_RUN;
   wire wd_event = watchdog_timeout && state == ST_RUN && !pin_event && !bo_event;
   wire wake_irq = irq_wake && sleeping && !pin_event && !bo_event && !wd_event;
   wire any_reset = pin_event || bo_event || (wd_event && !sleeping);
   wire wd_wake = wd_event && sleeping;
   wire wake_any = wd_wake || wake_irq;

   // time-out selection per oscillator mode
   wire need_pup = bo_event || !powerup_timer_enable_n || rc_mode;
   wire need_osc = !rc_mode;
   // power-on loads the power-up count too, so the counter never starts from zero
   assign load_pup = (any_reset && need_pup) || first_load;
   assign load_osc = (any_reset && !need_pup && need_osc) || (wake_any && need_osc) ||
                     (state == ST_POWERUP && pup_done && need_osc);

   seq_state_t next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (any_reset && need_pup) next_state = ST_POWERUP;
            else if ((any_reset || wake_any) && need_osc) next_state = ST_OSC;
         end
         ST_POWERUP: begin
            if (pup_done) next_state = need_osc ? ST_OSC : ST_RUN;
         end
         ST_OSC: begin
            if (osc_done) next_state = ST_RUN;
         end
         default: next_state = ST_RUN;
      endcase
   end

   // power-on starts with the full power-up sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_POWERUP;
      end else begin
         state <= next_state;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) first_load <= 1'b1;
      else first_load <= 1'b0;
   end

   // core held in reset until the selected time-out is over
   assign core_reset_n = (state == ST_RUN) && !first_load;
   assign fetch_enable = core_reset_n && !sleeping;
   // watchdog resets act internally; pin is never driven
   assign external_reset_pin_out = 1'b1;
   assign external_reset_pin_oe = 1'b1;

   // apb decode
   wire [7:0] word_addr = paddr[7:0];
   wire hit_status = word_addr == OFF_POWER_STATUS;
   wire hit_config = word_addr == OFF_CONFIG;
   wire hit_timer = word_addr == OFF_TIMER;
   wire hit_conv = word_addr == OFF_CONVERTER;
   wire hit_irq = word_addr == OFF_IRQ;
   wire hit_dir = word_addr == OFF_DIR;
   wire known = hit_status || hit_config || hit_timer || hit_conv || hit_irq || hit_dir ||
                word_addr == OFF_FLAGS || word_addr == OFF_CAUSE || word_addr == OFF_PC;
   // config word only reachable in programming mode
   wire cfg_ok = programming_mode;
   wire bad = !known || (hit_config && !cfg_ok) || paddr[31:8] != 24'h000000;
   assign pready = 1'b1;
   assign pslverr = psel && penable && bad;
   // a refused access writes nothing
   wire wr_en = psel && penable && pwrite && !bad;

   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h00000000;
      case (word_addr)
         OFF_POWER_STATUS: next_prdata = {30'h0, power_status};
         OFF_FLAGS: next_prdata = {29'h0, sleeping, timeout_flag, powerdown_flag};
         OFF_CAUSE: next_prdata = {29'h0, last_cause};
         OFF_PC: next_prdata = {19'h0, program_counter};
         OFF_DIR: next_prdata = {8'h0, scratch, 2'h0, port_a_direction, port_b_direction};
         OFF_TIMER: next_prdata = {timer_period_register, timer2_control_register,
                                   timer2_count, option_register};
         OFF_CONVERTER: next_prdata = {24'h0, converter_control_register};
         OFF_IRQ: next_prdata = {16'h0, interrupt_control_register, peripheral_irq_flags};
         OFF_CONFIG: next_prdata = cfg_ok ? {18'h0, config_word} : 32'h00000000;
         default: next_prdata = 32'h00000000;
      endcase
   end
   // read data is combinational from registers so the zero-wait answer is correct
   assign prdata = (psel && !bad) ? next_prdata : 32'h00000000;

   // config word at location 2007h; unprogrammed bits read as one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) config_word <= 14'h3FFF;
      else if (wr_en && hit_config && cfg_ok) config_word <= pwdata[13:0];
   end

   // status flags
   wire sw_status = wr_en && hit_status;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_status <= 2'b01;
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
         sleeping <= 1'b0;
         last_cause <= CAUSE_POWERON;
      end else begin
         // hardware clear outranks a simultaneous software write
         if (bo_event) power_status[BROWNOUT_BIT] <= 1'b0;
         else if (sw_status) power_status[BROWNOUT_BIT] <= pwdata[BROWNOUT_BIT];
         if (sw_status) power_status[POWERON_BIT] <= pwdata[POWERON_BIT];
         if (bo_event) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
            sleeping <= 1'b0;
            last_cause <= CAUSE_BROWNOUT;
         end else if (pin_event) begin
            if (sleeping) begin
               timeout_flag <= 1'b1;
               powerdown_flag <= 1'b0;
            end
            sleeping <= 1'b0;
            last_cause <= sleeping ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
         end else if (wd_event) begin
            timeout_flag <= 1'b0;
            powerdown_flag <= !sleeping;
            sleeping <= 1'b0;
            last_cause <= sleeping ? CAUSE_WDOG_WAKE : CAUSE_WDOG_RESET;
         end else if (wake_irq) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
            sleeping <= 1'b0;
            last_cause <= CAUSE_IRQ_WAKE;
         end else if (sleep_exec && core_reset_n && !sleeping) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
            sleeping <= 1'b1;
         end
      end
   end

   // program counter and reset-state registers
   wire [12:0] wake_pc = (wake_irq && global_irq_enable) ? PC_VECTOR : sleep_pc + 13'h0001;
   wire wr_timer = wr_en && hit_timer;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter <= PC_RESET;
         port_a_direction <= DIR_A_RESET;
         port_b_direction <= DIR_B_RESET;
         option_register <= OPTION_RESET;
         timer_period_register <= PERIOD_RESET;
         timer2_count <= TIMER2_COUNT_RESET;
         timer2_control_register <= TIMER2_CTRL_RESET;
         converter_control_register <= CONVERTER_RESET;
         interrupt_control_register <= 8'h00;
         peripheral_irq_flags <= 8'h00;
      end else if (any_reset) begin
         program_counter <= PC_RESET;
         port_a_direction <= DIR_A_RESET;
         port_b_direction <= DIR_B_RESET;
         option_register <= OPTION_RESET;
         timer_period_register <= PERIOD_RESET;
         timer2_count <= TIMER2_COUNT_RESET;
         timer2_control_register <= TIMER2_CTRL_RESET;
         converter_control_register <= CONVERTER_RESET;
         interrupt_control_register <= 8'h00;
         peripheral_irq_flags <= 8'h00;
      end else if (wake_any) begin
         program_counter <= wake_pc;
         peripheral_irq_flags <= peripheral_irq_flags | wake_flags;
         interrupt_control_register <= interrupt_control_register |
                                       (wake_irq ? 8'h01 : 8'h00);
      end else begin
         if (wr_timer) begin
            option_register <= pwdata[7:0];
            timer2_count <= pwdata[15:8];
            timer2_control_register <= pwdata[23:16] & TIMER2_CTRL_MASK;
            timer_period_register <= pwdata[31:24];
         end
         if (wr_en && hit_conv) converter_control_register <= pwdata[7:0] & CONVERTER_MASK;
         if (wr_en && hit_dir) {port_a_direction, port_b_direction} <= pwdata[13:0];
         if (wr_en && hit_irq) {interrupt_control_register, peripheral_irq_flags} <= pwdata[15:0];
      end
   end

   // no reset at all: undefined after power-on, kept across every later reset
   always_ff @(posedge pclk) begin
      if (wr_en && hit_dir) scratch <= pwdata[23:16];
   end

   a_pin_not_driven: assert property (@(posedge pclk) disable iff (!presetn)
      external_reset_pin_oe) else $error("reset pin driven");
   a_bo_clears_flag: assert property (@(posedge pclk) disable iff (!presetn)
      bo_event |=> !power_status[BROWNOUT_BIT]) else $error("brownout flag not cleared");
   a_wd_reset_flags: assert property (@(posedge pclk) disable iff (!presetn)
      (wd_event && !sleeping) |=> !timeout_flag && powerdown_flag) else $error("wd flags");
   a_wd_wake_flags: assert property (@(posedge pclk) disable iff (!presetn)
      wd_wake |=> !timeout_flag && !powerdown_flag) else $error("wake flags");
   a_reset_pc_zero: assert property (@(posedge pclk) disable iff (!presetn)
      any_reset |=> program_counter == PC_RESET) else $error("pc not zero");
   a_vector_on_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (wake_irq && global_irq_enable) |=> program_counter == PC_VECTOR) else $error("vec");
   a_dir_inputs: assert property (@(posedge pclk) disable iff (!presetn)
      any_reset |=> port_b_direction == DIR_B_RESET) else $error("dir not input");
   a_held_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
      any_reset |=> !core_reset_n) else $error("core released early");
   a_wake_keeps_conv: assert property (@(posedge pclk) disable iff (!presetn)
      wake_any |=> $stable(converter_control_register)) else $error("wake changed reg");
   c_brownout: cover property (@(posedge pclk) disable iff (!presetn) bo_event);
   c_wd_wake: cover property (@(posedge pclk) disable iff (!presetn) wd_wake);
   c_irq_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_irq);
   c_pin_sleep: cover property (@(posedge pclk) disable iff (!presetn) pin_event && sleeping);
   c_osc_wait: cover property (@(posedge pclk) disable iff (!presetn) state == ST_OSC);
   // flag checks look one cycle after the event that sets them
   a_bo_sets_flags: assert property (@(posedge pclk) disable iff (!presetn)
      bo_event |=> timeout_flag && powerdown_flag) else $error("bo flags");
   a_pin_run_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      (pin_event && !bo_event && !sleeping) |=> $stable(timeout_flag) && $stable(powerdown_flag))
      else $error("pin run flags");
   a_sleep_clears_pd: assert property (@(posedge pclk) disable iff (!presetn)
      (sleep_exec && core_reset_n && !sleeping && !any_reset) |=> !powerdown_flag && sleeping)
      else $error("sleep flags");
   a_wake_waits_osc: assert property (@(posedge pclk) disable iff (!presetn)
      (wake_any && need_osc) |=> !fetch_enable) else $error("wake no osc wait");
   a_poweron_kept: assert property (@(posedge pclk) disable iff (!presetn)
      !sw_status |=> $stable(power_status[POWERON_BIT])) else $error("por flag moved");
endmodule // reset_cause_unit
`default_nettype wire

// ### verilog/reset_cause_pkg.sv
// Purpose: shared constants for the reset cause and time-out unit
// Assumes: 250 MHz pclk, APB register access
// Notes: time-outs are counted in pclk cycles or oscillator periods
package reset_cause_pkg;
   localparam logic [11:0] CFG_WORD_ADDR = 12'h007;
   localparam logic [15:0] CFG_SPACE_BASE = 16'h2000;
   localparam logic [15:0] CFG_SPACE_LAST = 16'h3FFF;
   localparam logic [15:0] CFG_WORD_LOC = 16'h2007;
   localparam logic [7:0] OFF_POWER_STATUS = 8'h00;
   localparam logic [7:0] OFF_FLAGS = 8'h04;
   localparam logic [7:0] OFF_CAUSE = 8'h08;
   localparam logic [7:0] OFF_PC = 8'h0C;
   localparam logic [7:0] OFF_DIR = 8'h10;
   localparam logic [7:0] OFF_TIMER = 8'h14;
   localparam logic [7:0] OFF_CONVERTER = 8'h18;
   localparam logic [7:0] OFF_IRQ = 8'h1C;
   localparam logic [7:0] OFF_CONFIG = 8'h20;
   localparam int BROWNOUT_BIT = 0;
   localparam int POWERON_BIT = 1;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_VECTOR = 13'h0004;
   localparam logic [5:0] DIR_A_RESET = 6'h3F;
   localparam logic [7:0] DIR_B_RESET = 8'hFF;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [7:0] TIMER2_COUNT_RESET = 8'h00;
   localparam logic [7:0] TIMER2_CTRL_RESET = 8'h00;
   localparam logic [7:0] TIMER2_CTRL_MASK = 8'h7F;
   localparam logic [7:0] CONVERTER_RESET = 8'h00;
   localparam logic [7:0] CONVERTER_MASK = 8'hFD;
   localparam int POWERUP_TIME_MS = 72;
   localparam int CLK_MHZ = 250;
   localparam int POWERUP_CYCLES = POWERUP_TIME_MS * 1000 * CLK_MHZ;
   localparam int OSC_STARTUP_PERIODS = 1024;
   localparam int FILTER_CYCLES = 4;
   typedef enum logic [2:0] {
      CAUSE_NONE = 3'b000,
      CAUSE_POWERON = 3'b001,
      CAUSE_PIN_RUN = 3'b010,
      CAUSE_PIN_SLEEP = 3'b011,
      CAUSE_WDOG_RESET = 3'b100,
      CAUSE_WDOG_WAKE = 3'b101,
      CAUSE_BROWNOUT = 3'b110,
      CAUSE_IRQ_WAKE = 3'b111
   } cause_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_POWERUP = 2'b01,
      ST_OSC = 2'b10
   } seq_state_t;
endpackage

// ### verilog/pin_glitch_filter.sv
// Purpose: synchronise the external reset pin and reject short pulses
// Assumes: pin is asynchronous to pclk
// Notes: a level change counts only after it stays stable for the filter span
`timescale 1ns/1ns
`default_nettype none
module pin_glitch_filter
   import reset_cause_pkg::*;
#(
   parameter int SPAN = FILTER_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_n,
   output logic filtered_n
);
   localparam int CNT_W = $clog2(SPAN + 1);
   logic [2:0] sync;
   logic [CNT_W-1:0] stable_cnt;
   wire agree = (sync[1] == sync[2]);
   wire differs = agree && (sync[2] != filtered_n);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync <= 3'h7;
      end else begin
         sync <= {sync[1:0], pin_n};
      end
   end
   // short pulses restart the count and never reach the output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_cnt <= '0;
         filtered_n <= 1'b1;
      end else if (!differs) begin
         stable_cnt <= '0;
      end else if (stable_cnt == CNT_W'(SPAN - 1)) begin
         stable_cnt <= '0;
         filtered_n <= sync[2];
      end else begin
         stable_cnt <= stable_cnt + 1'b1;
      end
   end
endmodule // pin_glitch_filter
`default_nettype wire

// ### verilog/timeout_counter.sv
// Purpose: down counter for the power-up and oscillator start-up time-outs
// Assumes: osc_tick pulses once per oscillator period
// Notes: done is a level that stays high until the next load
`timescale 1ns/1ns
`default_nettype none
module timeout_counter #(
   parameter int WIDTH = 25
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   input wire logic tick,
   output logic done
);
   logic [WIDTH-1:0] remain;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain <= '0;
      end else if (load) begin
         remain <= count;
      end else if (tick && remain != '0) begin
         remain <= remain - 1'b1;
      end
   end
   assign done = (remain == '0) && !load;
endmodule // timeout_counter
`default_nettype wire

// ### dv/pin_osc_model.sv
// Purpose: far side of the reset pin and the oscillator tick source
// Assumes: the pin has a pull-up, one oscillator period is two pclk cycles
// Notes: hold_low stands for something outside pulling the pin down
`timescale 1ns/1ns
`default_nettype none
module pin_osc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold_low,
   input wire logic pin_oe,
   input wire logic pin_out,
   output logic pin_n,
   output logic osc_tick
);
   // oe high means the device has let go, so the pull-up sets the level
   assign pin_n = hold_low ? 1'b0 : (pin_oe ? 1'b1 : pin_out);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_tick <= 1'b0;
      end else begin
         osc_tick <= ~osc_tick;
      end
   end
endmodule // pin_osc_model
`default_nettype wire

// ### dv/reset_cause_unit_bench.sv
// Purpose: self-checking bench for the reset cause and time-out unit
// Assumes: shortened time-out counts, APB master with idle cycle between transfers
// Notes: event pulses go in as a 4-bit vector {sleep, irq, watchdog, brownout}
`timescale 1ns/1ns
`default_nettype none
module reset_cause_unit_bench;
   import reset_cause_pkg::*;
   localparam int PU = 20;
   localparam int OC = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [3:0] ev;
   logic [12:0] sleep_pc;
   logic [7:0] wake_flags;
   logic global_irq_enable, programming_mode, hold_low, pin_n, osc_tick;
   logic pin_out, pin_oe, core_reset_n, fetch_enable;
   int error_cnt = 0;
   int num_checks = 0;
   int n;
   reset_cause_unit #(.POWERUP_COUNT(PU), .OSC_COUNT(OC)) dut_u (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .external_reset_pin_n(pin_n), .brownout_detect(ev[0]),
      .watchdog_timeout(ev[1]), .irq_wake(ev[2]), .sleep_exec(ev[3]), .sleep_pc,
      .global_irq_enable, .wake_flags, .osc_tick, .programming_mode,
      .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe), .core_reset_n,
      .fetch_enable, .program_counter(), .port_a_direction(), .port_b_direction(),
      .option_register(), .timer_period_register(), .timer2_count(),
      .timer2_control_register(), .converter_control_register(),
      .interrupt_control_register(), .peripheral_irq_flags(), .scratch()
   );
   pin_osc_model far_u (
      .pclk, .presetn, .hold_low, .pin_oe, .pin_out, .pin_n, .osc_tick
   );
   always #2 pclk = ~pclk;
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h000000, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         error_cnt++;
         close_out();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(q, exp);
   endtask
   task automatic pulse(input logic [3:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 4'h0;
      @(posedge pclk);
   endtask
   // waits for fetch to resume; n counts cycles after the first three
   task automatic wait_run;
      n = 0;
      repeat (3) @(posedge pclk);
      while (fetch_enable !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 300) begin
         error_cnt++;
         close_out();
      end
   endtask
   task automatic pin_low(input int c);
      hold_low <= 1'b1;
      repeat (c) @(posedge pclk);
      hold_low <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic dirty;
      apb(1'b1, OFF_DIR, 32'h005A0000);
      apb(1'b1, OFF_TIMER, 32'h12345678);
      apb(1'b1, OFF_CONVERTER, 32'h00000081);
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, global_irq_enable, programming_mode, hold_low} = 6'h00;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      ev = 4'h0;
      sleep_pc = 13'h0000;
      wake_flags = 8'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_run();
      check({31'h0, n + 3 >= PU}, 32'h1);
      rd(OFF_POWER_STATUS, 32'h1);
      rd(OFF_FLAGS, 32'h3);
      rd(OFF_CAUSE, {29'h0, CAUSE_POWERON});
      rd(OFF_PC, {19'h0, PC_RESET});
      apb(1'b0, OFF_DIR, 32'h00000000);
      check(q & 32'h0000FFFF, {18'h0, DIR_A_RESET, DIR_B_RESET});
      rd(OFF_TIMER, {PERIOD_RESET, TIMER2_CTRL_RESET, TIMER2_COUNT_RESET, OPTION_RESET});
      rd(OFF_CONVERTER, {24'h0, CONVERTER_RESET});
      apb(1'b1, OFF_POWER_STATUS, 32'h00000003);
      rd(OFF_POWER_STATUS, 32'h3);
      rd(OFF_CONFIG, 32'h0);
      check({31'h0, err}, 32'h1);
      programming_mode <= 1'b1;
      rd(OFF_CONFIG, 32'h00003FFF);
      programming_mode <= 1'b0;
      rd(8'h24, 32'h0);
      check({31'h0, err}, 32'h1);
      // watchdog reset while running keeps the scratch byte
      dirty();
      pulse(4'h2);
      wait_run();
      check({30'h0, pin_oe, pin_n}, 32'h3);
      rd(OFF_FLAGS, 32'h1);
      rd(OFF_CAUSE, {29'h0, CAUSE_WDOG_RESET});
      rd(OFF_DIR, 32'h005A3FFF);
      rd(OFF_TIMER, 32'hFF0000FF);
      rd(OFF_CONVERTER, 32'h0);
      rd(OFF_POWER_STATUS, 32'h3);
      pin_low(12);
      wait_run();
      rd(OFF_FLAGS, 32'h1);
      rd(OFF_CAUSE, {29'h0, CAUSE_PIN_RUN});
      // watchdog wake from sleep resumes after the sleep instruction
      dirty();
      sleep_pc <= 13'h0123;
      pulse(4'h8);
      rd(OFF_FLAGS, 32'h6);
      check({31'h0, fetch_enable}, 32'h0);
      pulse(4'h2);
      wait_run();
      check({31'h0, n < PU}, 32'h1);
      rd(OFF_FLAGS, 32'h0);
      rd(OFF_PC, 32'h00000124);
      rd(OFF_DIR, 32'h005A0000);
      rd(OFF_TIMER, 32'h12345678);
      rd(OFF_CAUSE, {29'h0, CAUSE_WDOG_WAKE});
      apb(1'b1, OFF_IRQ, 32'h00008001);
      global_irq_enable <= 1'b1;
      wake_flags <= 8'h04;
      pulse(4'h8);
      pulse(4'h4);
      wait_run();
      rd(OFF_PC, {19'h0, PC_VECTOR});
      rd(OFF_IRQ, 32'h00008105);
      rd(OFF_FLAGS, 32'h2);
      rd(OFF_CAUSE, {29'h0, CAUSE_IRQ_WAKE});
      // a two-cycle dip must not reach the core
      pin_low(2);
      repeat (20) @(posedge pclk);
      check({31'h0, fetch_enable}, 32'h1);
      rd(OFF_CAUSE, {29'h0, CAUSE_IRQ_WAKE});
      pulse(4'h8);
      pin_low(12);
      wait_run();
      rd(OFF_FLAGS, 32'h2);
      rd(OFF_CAUSE, {29'h0, CAUSE_PIN_SLEEP});
      rd(OFF_PC, {19'h0, PC_RESET});
      pulse(4'h1);
      wait_run();
      check({31'h0, n + 3 >= PU}, 32'h1);
      rd(OFF_POWER_STATUS, 32'h2);
      rd(OFF_FLAGS, 32'h3);
      rd(OFF_CAUSE, {29'h0, CAUSE_BROWNOUT});
      // crystal mode, power-up timer off: a watchdog wake waits the oscillator only
      programming_mode <= 1'b1;
      apb(1'b1, OFF_CONFIG, 32'h00003FFC);
      programming_mode <= 1'b0;
      pulse(4'h8);
      pulse(4'h2);
      wait_run();
      check({31'h0, n + 3 >= 2 * OC - 2}, 32'h1);
      check({31'h0, n < PU}, 32'h1);
      rd(OFF_FLAGS, 32'h0);
      close_out();
   end
endmodule // reset_cause_unit_bench
`default_nettype wire
